// ---- hdl/power_mode_controller.sv ----
// Functional notes
// (RULE1) Full-on: PLL on, unbypassed, clocks, power on.
// (RULE2) Power-up enters full-on mode.
// (RULE3) Active: PLL bypassed, both clocks at input.
// (RULE4) New multiplier applied on next full-on entry.
// (RULE5) Active mode allows DMA to L1.
// (RULE6) Software re-enables PLL before full-on or sleep.
// (RULE7) Sleep stops core clock, keeps PLL, system clock.
// (RULE8) Sleep wakeup: bypass clear full-on, else active.
// (RULE9) No system DMA to L1 in sleep.
// (RULE10) Deep sleep stops clocks, PLL, async access.
// (RULE11) Deep sleep exits: RTC to active, reset full-on.
// (RULE12) Hibernate removes power; level zero lowers wake.
// (RULE13) Hibernate tristates external pins.
// (RULE14) PHY, RTC, reset wakes individually enabled.
// (RULE15) Hibernate wake starts reset, raises wake output.
// (RULE16) Wake output high requests core power.
// (RULE17) Only regulator control survives hibernate.
// (RULE18) Control bit holds SDRAM self-refresh through hibernate.
// (RULE19) Start waits for active-low power-good.
// (RULE20) Mode changes apply only once core idles.
module power_mode_controller #(
   parameter int SETTLE = pmc_pkg::SETTLE_CYC
) (
   input wire logic CLK_SYS,
   input wire logic RESET,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic CORE_IDLE,
   input wire logic WAKEUP,
   input wire logic RTC_IRQ,
   input wire logic RTC_WAKE,
   input wire logic RESET_PIN_ASSERTED,
   input wire logic PHY_WAKE_PIN_N,
   input wire logic POWER_GOOD_IN_N,
   output logic PLL_ENABLE,
   output logic PLL_BYPASS,
   output logic [pmc_pkg::MULT_W-1:0] PLL_MULT,
   output logic CORE_CLOCK_EN,
   output logic SYS_CLOCK_EN,
   output logic CORE_POWER_ON,
   output logic DMA_L1_EN,
   output logic ASYNC_ACCESS_EN,
   output logic PAD_OE_N,
   output logic EXTERNAL_WAKE_OUT,
   output logic SDRAM_SELF_REFRESH_HOLD,
   output logic HW_RESET_START,
   output logic [pmc_pkg::MODE_W-1:0] MODE
);
   import pmc_pkg::*;

   // ==========================================================
   // Register state.
   mode_t mode_q, mode_d;
   logic bypass_q, pll_off_q, pready_q, slverr_q;
   logic [MULT_W-1:0] mult_q, applied_q;
   logic [1:0] vr_level_q, vr_level_d;
   logic wk_phy_q, wk_rtc_q, wk_rst_q, hold_cfg_q, from_hib_q;
   logic [2:0] req_q;
   logic [31:0] rdata_q;
   logic pll_en_q, byp_out_q, core_clk_q, sys_clk_q, power_q, dma_q;
   logic async_q, oe_n_q, wake_q, hold_q, hw_rst_q;
   logic supply_ok;

   // ==========================================================
   // Bus decode.
   wire logic setup = PSEL & ~PENABLE;
   wire logic wr = PSEL & PENABLE & PWRITE & pready_q;
   wire logic hit_pll = PADDR == OFF_PLL_CTRL;
   wire logic hit_vr = PADDR == OFF_VR_CTRL;
   wire logic hit_req = PADDR == OFF_MODE_REQ;
   wire logic hit_st = PADDR == OFF_STATUS;
   wire logic mapped = hit_pll | hit_vr | hit_req | hit_st;
   wire logic wr_pll = wr & hit_pll & ~slverr_q;
   wire logic wr_vr = wr & hit_vr & ~slverr_q;
   wire logic wr_req = wr & hit_req & ~slverr_q;
   wire logic [31:0] pll_view = {18'h0, mult_q, 6'h0, pll_off_q, bypass_q};
   wire logic [31:0] vr_view = {20'h0, hold_cfg_q, wk_rst_q, wk_rtc_q, wk_phy_q,
                                6'h0, vr_level_q};
   wire logic [31:0] st_view = {18'h0, applied_q, 2'h0, wake_q, hold_q, 1'b0,
                                mode_q};
   wire logic [31:0] rd_mux = hit_pll ? pll_view : hit_vr ? vr_view :
                              hit_req ? {29'h0, req_q} : hit_st ? st_view : 32'h0;

   // ==========================================================
   // Mode sequencing conditions.
   wire logic running = mode_q == M_FULL_ON || mode_q == M_ACTIVE;
   wire logic take = running & CORE_IDLE; // [RULE20]
   wire logic hib_go = take & (vr_level_q == VR_LEVEL_OFF); // [RULE12]
   wire logic wake_any = (wk_phy_q & ~PHY_WAKE_PIN_N) | (wk_rtc_q & RTC_WAKE) |
                         (wk_rst_q & RESET_PIN_ASSERTED); // [RULE14]
   wire logic hib_wake = mode_q == M_HIBERNATE && wake_any;
   wire logic held = pll_off_q & (((req_q == REQ_APPLY) & ~bypass_q) | (req_q == REQ_SLEEP));
   wire logic req_used = take & ~hib_go & (req_q != REQ_NONE) & ~held; // [RULE6]
   wire logic enter_full = mode_d == M_FULL_ON && mode_q != M_FULL_ON;

   always_comb begin
      mode_d = mode_q;
      case (mode_q)
         M_STARTUP: begin
            if (supply_ok) mode_d = M_FULL_ON; // [RULE2] [RULE19]
         end
         M_FULL_ON, M_ACTIVE: begin
            if (hib_go) begin
               mode_d = M_HIBERNATE; // [RULE12]
            end else if (take) begin
               case (req_q)
                  // A request that would need the PLL while it is stopped is held back.
                  REQ_APPLY: begin
                     if (bypass_q) mode_d = M_ACTIVE; // [RULE3]
                     else if (!pll_off_q) mode_d = M_FULL_ON; // [RULE6]
                  end
                  REQ_SLEEP: begin
                     if (!pll_off_q) mode_d = M_SLEEP; // [RULE6]
                  end
                  REQ_DEEP: mode_d = M_DEEP;
                  default: mode_d = mode_q;
               endcase
            end
         end
         M_SLEEP: begin
            if (WAKEUP) mode_d = bypass_q ? M_ACTIVE : M_FULL_ON; // [RULE8]
         end
         M_DEEP: begin
            if (RESET_PIN_ASSERTED) mode_d = M_FULL_ON; // [RULE11]
            else if (RTC_IRQ) mode_d = M_ACTIVE; // [RULE11]
         end
         M_HIBERNATE: begin
            if (wake_any) mode_d = M_STARTUP; // [RULE15]
         end
         default: mode_d = M_STARTUP;
      endcase
   end

   // Level back at its reset value after a wake brings the wake output up.
   always_comb begin
      vr_level_d = vr_level_q;
      if (hib_wake) vr_level_d = VR_LEVEL_RST; // [RULE15]
      else if (wr_vr) vr_level_d = PWDATA[VR_LEVEL_LSB +: 2];
   end

   supply_settle #(.CYCLES(SETTLE)) u_settle (
      .clk(CLK_SYS),
      .rst(RESET),
      .arm(mode_q == M_STARTUP),
      .good_n(POWER_GOOD_IN_N),
      .ready_q(supply_ok)
   );

   // ==========================================================
   // Bus slave flops.
   always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET) begin
         pready_q <= 1'b0;
         slverr_q <= 1'b0;
         rdata_q <= 32'h0;
      end else begin
         pready_q <= setup;
         slverr_q <= setup & ~mapped;
         if (setup) rdata_q <= rd_mux;
      end
   end

   // ==========================================================
   // Software registers; the PLL side is lost across hibernate.
   always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET) begin
         bypass_q <= 1'b0;
         pll_off_q <= 1'b0;
         mult_q <= PLL_MULT_RST;
         req_q <= REQ_NONE;
      end else if (hib_wake) begin
         bypass_q <= 1'b0; // [RULE17]
         pll_off_q <= 1'b0;
         mult_q <= PLL_MULT_RST;
         req_q <= REQ_NONE;
      end else begin
         if (wr_pll) begin
            bypass_q <= PWDATA[PLL_BYPASS_BIT];
            pll_off_q <= PWDATA[PLL_OFF_BIT];
            mult_q <= PWDATA[PLL_MULT_LSB +: MULT_W]; // [RULE4]
         end
         if (wr_req) req_q <= PWDATA[2:0];
         else if (req_used) req_q <= REQ_NONE;
      end
   end

   always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET) begin
         vr_level_q <= VR_LEVEL_RST;
         wk_phy_q <= 1'b0;
         wk_rtc_q <= 1'b0;
         wk_rst_q <= 1'b0;
         hold_cfg_q <= 1'b0;
      end else begin
         vr_level_q <= vr_level_d; // [RULE17]
         if (wr_vr) begin
            wk_phy_q <= PWDATA[VR_PHY_WAKE_BIT];
            wk_rtc_q <= PWDATA[VR_RTC_WAKE_BIT];
            wk_rst_q <= PWDATA[VR_RST_WAKE_BIT];
            hold_cfg_q <= PWDATA[VR_SDRAM_HOLD_BIT];
         end
      end
   end

   // ==========================================================
   // Mode and output flops, decoded from the next mode except wake_q (next level) and hw_rst_q (hib_wake).
   always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET) begin
         mode_q <= M_STARTUP;
         applied_q <= PLL_MULT_RST;
         from_hib_q <= 1'b0;
         pll_en_q <= 1'b0;
         byp_out_q <= 1'b0;
         core_clk_q <= 1'b0;
         sys_clk_q <= 1'b0;
         power_q <= 1'b1;
         dma_q <= 1'b0;
         async_q <= 1'b0;
         oe_n_q <= 1'b0;
         wake_q <= 1'b1;
         hold_q <= 1'b0;
         hw_rst_q <= 1'b0;
      end else begin
         mode_q <= mode_d;
         if (enter_full) applied_q <= mult_q; // [RULE4]
         if (hib_wake) from_hib_q <= 1'b1;
         else if (mode_d != M_STARTUP) from_hib_q <= 1'b0;
         pll_en_q <= mode_d == M_FULL_ON || mode_d == M_SLEEP ||
                     (mode_d == M_ACTIVE && !pll_off_q); // [RULE1] [RULE7] [RULE10]
         byp_out_q <= mode_d == M_ACTIVE; // [RULE3]
         core_clk_q <= mode_d == M_FULL_ON || mode_d == M_ACTIVE; // [RULE7]
         sys_clk_q <= mode_d == M_FULL_ON || mode_d == M_ACTIVE ||
                      mode_d == M_SLEEP; // [RULE10]
         power_q <= mode_d != M_HIBERNATE; // [RULE12]
         dma_q <= mode_d == M_FULL_ON || mode_d == M_ACTIVE; // [RULE5] [RULE9]
         async_q <= mode_d != M_DEEP && mode_d != M_HIBERNATE; // [RULE10]
         oe_n_q <= mode_d == M_HIBERNATE; // [RULE13]
         wake_q <= vr_level_d != VR_LEVEL_OFF; // [RULE12] [RULE16]
         hold_q <= hold_cfg_q && (mode_d == M_HIBERNATE ||
                   (mode_d == M_STARTUP && (from_hib_q || hib_wake))); // [RULE18]
         hw_rst_q <= hib_wake; // [RULE15]
      end
   end

   assign PRDATA = rdata_q;
   assign PREADY = pready_q;
   assign PSLVERR = slverr_q;
   assign PLL_ENABLE = pll_en_q;
   assign PLL_BYPASS = byp_out_q;
   assign PLL_MULT = applied_q;
   assign CORE_CLOCK_EN = core_clk_q;
   assign SYS_CLOCK_EN = sys_clk_q;
   assign CORE_POWER_ON = power_q;
   assign DMA_L1_EN = dma_q;
   assign ASYNC_ACCESS_EN = async_q;
   assign PAD_OE_N = oe_n_q;
   assign EXTERNAL_WAKE_OUT = wake_q;
   assign SDRAM_SELF_REFRESH_HOLD = hold_q;
   assign HW_RESET_START = hw_rst_q;
   assign MODE = mode_q;

   // ==========================================================
   // Checks.
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (RESET);

   property p_full_on;
      mode_q == M_FULL_ON |-> pll_en_q && !byp_out_q && core_clk_q && sys_clk_q && power_q;
   endproperty
   a_full_on: assert property (p_full_on) else $error("full-on settings wrong"); // [RULE1]
   property p_active;
      mode_q == M_ACTIVE |-> byp_out_q && core_clk_q && sys_clk_q && dma_q;
   endproperty
   a_active: assert property (p_active) else $error("active settings wrong"); // [RULE3]
   property p_sleep;
      mode_q == M_SLEEP |-> !core_clk_q && sys_clk_q && pll_en_q && !dma_q;
   endproperty
   a_sleep: assert property (p_sleep) else $error("sleep settings wrong"); // [RULE7]
   property p_sleep_wake;
      mode_q == M_SLEEP && WAKEUP |=> mode_q == ($past(bypass_q) ? M_ACTIVE : M_FULL_ON);
   endproperty
   a_sleep_wake: assert property (p_sleep_wake) else $error("sleep wake target wrong"); // [RULE8]
   property p_deep;
      mode_q == M_DEEP |-> !core_clk_q && !sys_clk_q && !pll_en_q && !async_q;
   endproperty
   a_deep: assert property (p_deep) else $error("deep sleep settings wrong"); // [RULE10]
   property p_deep_exit;
      mode_q == M_DEEP && !RESET_PIN_ASSERTED && RTC_IRQ |=> mode_q == M_ACTIVE;
   endproperty
   a_deep_exit: assert property (p_deep_exit) else $error("rtc exit wrong"); // [RULE11]
   property p_level_off;
      wr_vr && PWDATA[1:0] == VR_LEVEL_OFF && !hib_wake |=> !wake_q;
   endproperty
   a_level_off: assert property (p_level_off) else $error("wake output not low"); // [RULE12]
   property p_pads;
      mode_q == M_HIBERNATE |-> oe_n_q && !power_q;
   endproperty
   a_pads: assert property (p_pads) else $error("pins driven in hibernate"); // [RULE13]
   property p_hib_wake;
      hib_wake |=> hw_rst_q && wake_q ##1 !hw_rst_q;
   endproperty
   a_hib_wake: assert property (p_hib_wake) else $error("wake reset pulse wrong"); // [RULE15]
   property p_supply;
      mode_q == M_STARTUP && POWER_GOOD_IN_N |=> mode_q == M_STARTUP [*2];
   endproperty
   a_supply: assert property (p_supply) else $error("started without supply"); // [RULE19]
   property p_idle;
      running && !CORE_IDLE |=> mode_q == $past(mode_q);
   endproperty
   a_idle: assert property (p_idle) else $error("mode changed while busy"); // [RULE20]
   c_sleep: cover property (mode_q == M_SLEEP ##1 mode_q == M_FULL_ON);
   c_deep: cover property (mode_q == M_DEEP ##1 mode_q == M_ACTIVE);
   c_hib: cover property (mode_q == M_HIBERNATE ##1 mode_q == M_STARTUP);
endmodule // power_mode_controller

// ---- shared/pmc_pkg.sv ----
package pmc_pkg;
   // ==========================================================
   // Register map.
   localparam logic [7:0] OFF_PLL_CTRL = 8'h00;
   localparam logic [7:0] OFF_VR_CTRL = 8'h04;
   localparam logic [7:0] OFF_MODE_REQ = 8'h08;
   localparam logic [7:0] OFF_STATUS = 8'h0c;
   // ==========================================================
   // Field positions.
   localparam int PLL_BYPASS_BIT = 0;
   localparam int PLL_OFF_BIT = 1;
   localparam int PLL_MULT_LSB = 8;
   localparam int MULT_W = 6;
   localparam int VR_LEVEL_LSB = 0;
   localparam int VR_PHY_WAKE_BIT = 8;
   localparam int VR_RTC_WAKE_BIT = 9;
   localparam int VR_RST_WAKE_BIT = 10;
   localparam int VR_SDRAM_HOLD_BIT = 11;
   localparam int MODE_W = 3;
   localparam int ST_HOLD_BIT = 4;
   localparam int ST_WAKE_BIT = 5;
   // ==========================================================
   // Reset values and codes.
   localparam logic [MULT_W-1:0] PLL_MULT_RST = 6'h06;
   localparam logic [1:0] VR_LEVEL_RST = 2'h3;
   localparam logic [1:0] VR_LEVEL_OFF = 2'h0;
   localparam logic [2:0] REQ_NONE = 3'h0;
   localparam logic [2:0] REQ_APPLY = 3'h1;
   localparam logic [2:0] REQ_SLEEP = 3'h2;
   localparam logic [2:0] REQ_DEEP = 3'h3;
   // ==========================================================
   // Timing.
   localparam int CLK_PERIOD_NS = 8;
   localparam int SETTLE_NS = 80;
   localparam int SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // ==========================================================
   // Operating modes.
   typedef enum logic [MODE_W-1:0] {
      M_STARTUP, M_FULL_ON, M_ACTIVE, M_SLEEP, M_DEEP, M_HIBERNATE
   } mode_t;
endpackage

// ---- hdl/supply_settle.sv ----
module supply_settle #(
   parameter int CYCLES = 10
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic arm,
   input wire logic good_n,
   output logic ready_q
);
   localparam int CW = $clog2(CYCLES + 1);
   localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);
   logic [CW-1:0] cnt_q;
   wire logic steady = arm & ~good_n;
   // ==========================================================
   // Counts consecutive cycles of a good supply before release.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_q <= '0;
         ready_q <= 1'b0;
      end else begin
         cnt_q <= (steady && cnt_q != LAST) ? cnt_q + 1'b1 : '0;
         ready_q <= steady && cnt_q == LAST;
      end
   end
endmodule // supply_settle

// ---- verif/regulator_model.sv ----
module regulator_model #(
   parameter int RAMP = 5
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic external_wake_out,
   input wire logic phy_pull,
   output logic power_good_n,
   output logic phy_wake_pin_n
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================================
   // Supply ramps after a wake request and collapses on shutdown.
   int cnt;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt <= 0;
         power_good_n <= 1'b1;
      end else if (!external_wake_out) begin
         cnt <= 0;
         power_good_n <= 1'b1;
      end else if (cnt < RAMP) begin
         cnt <= cnt + 1;
      end else begin
         power_good_n <= 1'b0;
      end
   end
   // Pull-up holds the wake pin high unless the PHY pulls it down.
   assign phy_wake_pin_n = phy_pull ? 1'b0 : 1'b1;
endmodule // regulator_model

// ---- verif/power_mode_controller_bench.sv ----
module power_mode_controller_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import pmc_pkg::*;
   typedef struct {logic [31:0] v; logic [31:0] m; logic e;} note_t;
   localparam logic [10:0] EN_FULL = 11'b10111110100;
   localparam logic [10:0] EN_ACT = 11'b11111110100;
   localparam logic [10:0] EN_SLP = 11'b10011010100;
   localparam logic [10:0] EN_DEEP = 11'b00001000100;
   localparam logic [10:0] MK_RUN = 11'b11111111101;
   logic CLK_SYS, RESET, PSEL, PENABLE, PWRITE, CORE_IDLE, WAKEUP, RTC_IRQ, RTC_WAKE;
   logic RESET_PIN_ASSERTED, phy_pull, PHY_WAKE_PIN_N, POWER_GOOD_IN_N, h;
   logic [7:0] PADDR;
   logic [31:0] PWDATA, PRDATA;
   logic PREADY, PSLVERR, PLL_ENABLE, PLL_BYPASS, CORE_CLOCK_EN, SYS_CLOCK_EN, CORE_POWER_ON;
   logic DMA_L1_EN, ASYNC_ACCESS_EN, PAD_OE_N, EXTERNAL_WAKE_OUT, SDRAM_SELF_REFRESH_HOLD;
   logic HW_RESET_START;
   logic [MULT_W-1:0] PLL_MULT, m;
   logic [MODE_W-1:0] MODE, last_mode;
   logic [10:0] outs;
   note_t aq[$];
   note_t mq[$];
   int fails = 0;
   int compares = 0;
   assign outs = {PLL_ENABLE, PLL_BYPASS, CORE_CLOCK_EN, SYS_CLOCK_EN, CORE_POWER_ON, DMA_L1_EN,
      ASYNC_ACCESS_EN, PAD_OE_N, EXTERNAL_WAKE_OUT, SDRAM_SELF_REFRESH_HOLD, HW_RESET_START};

   power_mode_controller #(.SETTLE(2)) DUT (.CLK_SYS(CLK_SYS), .RESET(RESET), .PSEL(PSEL),
      .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
      .PREADY(PREADY), .PSLVERR(PSLVERR), .CORE_IDLE(CORE_IDLE), .WAKEUP(WAKEUP),
      .RTC_IRQ(RTC_IRQ), .RTC_WAKE(RTC_WAKE), .RESET_PIN_ASSERTED(RESET_PIN_ASSERTED),
      .PHY_WAKE_PIN_N(PHY_WAKE_PIN_N), .POWER_GOOD_IN_N(POWER_GOOD_IN_N),
      .PLL_ENABLE(PLL_ENABLE), .PLL_BYPASS(PLL_BYPASS), .PLL_MULT(PLL_MULT),
      .CORE_CLOCK_EN(CORE_CLOCK_EN), .SYS_CLOCK_EN(SYS_CLOCK_EN),
      .CORE_POWER_ON(CORE_POWER_ON), .DMA_L1_EN(DMA_L1_EN), .ASYNC_ACCESS_EN(ASYNC_ACCESS_EN),
      .PAD_OE_N(PAD_OE_N), .EXTERNAL_WAKE_OUT(EXTERNAL_WAKE_OUT),
      .SDRAM_SELF_REFRESH_HOLD(SDRAM_SELF_REFRESH_HOLD), .HW_RESET_START(HW_RESET_START),
      .MODE(MODE));
   regulator_model #(.RAMP(5)) partner (.clk(CLK_SYS), .rst(RESET),
      .external_wake_out(EXTERNAL_WAKE_OUT), .phy_pull(phy_pull), .power_good_n(POWER_GOOD_IN_N),
      .phy_wake_pin_n(PHY_WAKE_PIN_N));

   // ==========================================================
   // Checking.
   task automatic report_and_stop();
      $display("fails=%0d compares=%0d", fails, compares);
      if (fails == 0 && compares > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask
   function automatic note_t mnote(logic [2:0] md, logic [10:0] en, logic [10:0] mk);
      mnote = '{{18'h0, md, en & mk}, {18'h0, 3'h7, mk}, 1'b0};
   endfunction
   always @(posedge CLK_SYS) begin
      note_t n;
      if (PSEL === 1'b1 && PENABLE === 1'b1 && PREADY === 1'b1 && aq.size() > 0) begin
         n = aq.pop_front();
         check("read data", n.v & n.m, PRDATA & n.m);
         check("slave error", {31'h0, n.e}, {31'h0, PSLVERR});
      end
      if (RESET === 1'b0 && MODE !== last_mode) begin
         if (mq.size() == 0) check("unexpected mode", {29'h0, last_mode}, {29'h0, MODE});
         else begin
            n = mq.pop_front();
            check("mode outputs", n.v, {18'h0, MODE, outs} & n.m);
         end
         last_mode = MODE;
      end
   end

   // ==========================================================
   // Stimulus.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
         input logic [31:0] ev, input logic [31:0] em, input logic ee);
      int n;
      aq.push_back('{ev, em, ee});
      PSEL <= 1'b1;
      PENABLE <= 1'b0;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CLK_SYS);
      PENABLE <= 1'b1;
      n = 0;
      do begin
         @(posedge CLK_SYS);
         n++;
      end while (PREADY !== 1'b1);
      check("ready wait", 32'h1, 32'(n));
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      @(posedge CLK_SYS);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 32'h0, 32'h0, 1'b0);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] ev, input logic [31:0] em);
      apb(1'b0, a, 32'h0, ev, em, 1'b0);
   endtask
   task automatic req(input logic [2:0] code);
      wr(OFF_MODE_REQ, {29'h0, code});
   endtask
   task automatic drain();
      int n = 0;
      while (mq.size() != 0 && n < 300) begin
         @(posedge CLK_SYS);
         n++;
      end
      if (mq.size() != 0) check("pending modes", 32'h0, 32'(mq.size()));
      mq.delete();
   endtask
   task automatic src(input int k, input logic v);
      case (k)
         0: phy_pull <= v;
         1: RTC_WAKE <= v;
         2: RESET_PIN_ASSERTED <= v;
         3: WAKEUP <= v;
         default: RTC_IRQ <= v;
      endcase
   endtask
   task automatic fire(input int k, input int c);
      src(k, 1'b1);
      repeat (c) @(posedge CLK_SYS);
      src(k, 1'b0);
      @(posedge CLK_SYS);
   endtask
   task automatic sleep_cycle(input logic [2:0] back, input logic [10:0] en);
      mq.push_back(mnote(3'h3, EN_SLP, MK_RUN));
      req(REQ_SLEEP);
      drain();
      repeat (1 + $urandom % 3) @(posedge CLK_SYS);
      mq.push_back(mnote(back, en, MK_RUN));
      fire(3, 1);
      drain();
   endtask

   initial begin
      CLK_SYS = 1'b0;
      forever #4 CLK_SYS = ~CLK_SYS;
   end
   initial begin
      repeat (20000) @(posedge CLK_SYS);
      fails++;
      report_and_stop();
   end
   initial begin
      RESET = 1'b1;
      PSEL = 1'b0;
      PENABLE = 1'b0;
      PWRITE = 1'b0;
      PADDR = 8'h00;
      PWDATA = 32'h0;
      CORE_IDLE = 1'b1;
      WAKEUP = 1'b0;
      RTC_IRQ = 1'b0;
      RTC_WAKE = 1'b0;
      RESET_PIN_ASSERTED = 1'b0;
      phy_pull = 1'b0;
      last_mode = 3'h0;
      void'($urandom(11));
      m = 6'(7 + $urandom % 57);
      mq.push_back(mnote(3'h1, EN_FULL, MK_RUN));
      repeat (12) @(posedge CLK_SYS);
      RESET <= 1'b0;
      repeat (4) @(posedge CLK_SYS);
      check("mode before power good", 32'h0, {29'h0, MODE});
      drain();
      check("reset multiplier", 32'h6, {26'h0, PLL_MULT});
      rd(OFF_PLL_CTRL, 32'h0600, 32'hffffffff);
      rd(OFF_VR_CTRL, 32'h3, 32'hffffffff);
      rd(OFF_STATUS, 32'h0621, 32'h3f37);
      apb(1'b1, 8'h10, 32'hffffffff, 32'h0, 32'h0, 1'b1);
      apb(1'b0, 8'h10, 32'h0, 32'h0, 32'hffffffff, 1'b1);
      CORE_IDLE <= 1'b0;
      wr(OFF_PLL_CTRL, 32'h0601);
      req(REQ_APPLY);
      repeat (6) @(posedge CLK_SYS);
      mq.push_back(mnote(3'h2, EN_ACT, MK_RUN));
      CORE_IDLE <= 1'b1;
      drain();
      wr(OFF_PLL_CTRL, {18'h0, m, 8'h01});
      repeat (2) @(posedge CLK_SYS);
      check("deferred multiplier", 32'h6, {26'h0, PLL_MULT});
      sleep_cycle(3'h2, EN_ACT);
      wr(OFF_PLL_CTRL, {18'h0, m, 8'h02});
      repeat (2) @(posedge CLK_SYS);
      check("pll stopped", 32'h0, {31'h0, PLL_ENABLE});
      req(REQ_APPLY);
      repeat (6) @(posedge CLK_SYS);
      mq.push_back(mnote(3'h1, EN_FULL, MK_RUN));
      wr(OFF_PLL_CTRL, {18'h0, m, 8'h00});
      drain();
      check("applied multiplier", {26'h0, m}, {26'h0, PLL_MULT});
      rd(OFF_STATUS, {18'h0, m, 8'h21}, 32'h3f37);
      sleep_cycle(3'h1, EN_FULL);
      mq.push_back(mnote(3'h4, EN_DEEP, MK_RUN));
      req(REQ_DEEP);
      drain();
      mq.push_back(mnote(3'h2, EN_ACT, MK_RUN));
      fire(4, 2);
      drain();
      mq.push_back(mnote(3'h4, EN_DEEP, MK_RUN));
      req(REQ_DEEP);
      drain();
      mq.push_back(mnote(3'h1, EN_FULL, MK_RUN));
      src(4, 1'b1);
      src(2, 1'b1);
      repeat (2) @(posedge CLK_SYS);
      src(4, 1'b0);
      src(2, 1'b0);
      drain();
      for (int i = 0; i < 3; i++) begin
         h = (i == 0);
         mq.push_back(mnote(3'h5, {8'h01, 1'b0, h, 1'b0}, 11'h7ff));
         wr(OFF_VR_CTRL, {20'h0, h, 3'(1 << i), 8'h00});
         drain();
         fire((i + 1) % 3, 4);
         mq.push_back(mnote(3'h0, {4'h0, 1'b1, 3'h0, 1'b1, h, 1'b1}, 11'h047));
         mq.push_back(mnote(3'h1, EN_FULL, MK_RUN));
         fire(i, 2);
         drain();
         rd(OFF_VR_CTRL, {20'h0, h, 3'(1 << i), 8'h03}, 32'hffffffff);
         rd(OFF_PLL_CTRL, 32'h0600, 32'hffffffff);
      end
      report_and_stop();
   end
endmodule // power_mode_controller_bench
